// ### shared/acr_pkg.sv
// Purpose: shared constants and decoders for the command fifo router ends
// Assumes: register port with byte offsets, 32-bit quadlets
// Notes:   control quadlet bit numbering is msb-first in print, lsb-first here
package acr_pkg;

	// register port offsets
	localparam logic [7:0] ADR_CTRL       = 8'h50;
	localparam logic [7:0] ADR_TX_FIRST   = 8'h70;
	localparam logic [7:0] ADR_TX_CONT    = 8'h74;
	localparam logic [7:0] ADR_TX_UPDATE  = 8'h78;
	localparam logic [7:0] ADR_RX_GENERAL = 8'h80;
	localparam logic [7:0] ADR_RX_MGMT    = 8'h84;
	localparam logic [7:0] ADR_RX_CMD     = 8'h88;

	// control register fields and reset value
	localparam int         CTRL_UNSOL_EN_BIT  = 0;
	localparam int         CTRL_UNSOL_IRQ_BIT = 1;
	localparam logic [1:0] CTRL_RESET         = 2'h0;

	// control quadlet field positions (lsb index)
	localparam int SPD_LSB   = 16;
	localparam int LABEL_LSB = 10;
	localparam int RT_LSB    = 8;
	localparam int TCODE_LSB = 4;
	localparam int PRIOR_LSB = 0;

	// transaction codes
	localparam logic [3:0] TC_WR_QUAD_REQ  = 4'h0;
	localparam logic [3:0] TC_WR_BLK_REQ   = 4'h1;
	localparam logic [3:0] TC_WR_RESP      = 4'h2;
	localparam logic [3:0] TC_RD_QUAD_REQ  = 4'h4;
	localparam logic [3:0] TC_RD_BLK_REQ   = 4'h5;
	localparam logic [3:0] TC_RD_QUAD_RESP = 4'h6;
	localparam logic [3:0] TC_RD_BLK_RESP  = 4'h7;
	localparam logic [3:0] TC_LOCK_REQ     = 4'h9;
	localparam logic [3:0] TC_LOCK_RESP    = 4'hb;

	localparam logic [1:0] SPD_UNDEFINED = 2'h3;

	// queue / fifo selectors
	typedef enum logic [1:0] {
		ACR_Q_GENERAL = 2'h0,
		ACR_Q_MGMT    = 2'h1,
		ACR_Q_CMD     = 2'h2,
		ACR_Q_DMA     = 2'h3
	} acr_queue_t;

	function automatic logic is_resp(input logic [3:0] tc);
		return tc == TC_WR_RESP || tc == TC_RD_QUAD_RESP || tc == TC_RD_BLK_RESP ||
			tc == TC_LOCK_RESP;
	endfunction : is_resp

	// labels held back for the device's own fetch and dma traffic
	function automatic logic is_reserved(input logic [5:0] lbl, input logic [3:0] tc);
		return (!is_resp(tc) && lbl[5:4] == 2'h1) ||
			(tc == TC_RD_BLK_REQ && (lbl == 6'h28 || lbl[5:3] == 3'h7));
	endfunction : is_reserved

endpackage : acr_pkg

// ### shared/acr_if.sv
// Purpose: register port joining the host end and the device end
// Assumes: one clock, host issues at most one access per cycle
// Notes:   read data answers one cycle after the read strobe
`timescale 1ns/1ps
interface acr_if;
	logic [7:0]  adr;
	logic        wr;
	logic [31:0] wdata;
	logic        rd;
	logic [31:0] rdata;
	logic        rvalid;

	modport host (output adr, output wr, output wdata, output rd, input rdata, input rvalid);
	modport dev  (input adr, input wr, input wdata, input rd, output rdata, output rvalid);
endinterface : acr_if

// ### rtl/acr_device.sv
// Purpose: device end - steers written packets to transmit queues, receive packets to fifos
// Assumes: link side presents one quadlet per cycle and honours o_rx_ready
// Notes:   transmit quadlets pass straight through, only receive is buffered
`timescale 1ns/1ps

module acr_device #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// register port
	acr_if.dev               bus,
	// link transmit side
	output logic             o_tx_valid,
	output logic [31:0]      o_tx_data,
	output logic [1:0]       o_tx_queue,
	output logic             o_tx_first,
	output logic             o_tx_last,
	output logic             o_tx_resp_expected,
	// link receive side
	input  wire logic        i_rx_valid,
	input  wire logic [31:0] i_rx_data,
	input  wire logic        i_rx_first,
	output logic             o_rx_ready,
	// dma receive fifo feed
	output logic             o_dma_valid,
	output logic [31:0]      o_dma_data,
	// status
	output logic             o_unsol_en
);
	localparam int NF = 3;
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] ROOM = (AW + 1)'(DEPTH - 2);

	typedef struct packed {
		logic [NF-1:0][DEPTH-1:0][31:0] mem;
		logic [NF-1:0][AW-1:0]          wp;
		logic [NF-1:0][AW-1:0]          rp;
		logic [NF-1:0][AW:0]            cnt;
		logic [1:0]                     tx_q;
		logic                           tx_unsol;
		logic [1:0]                     rx_sel;
		logic                           unsol_en;
		logic                           unsol_irq_en;
		logic                           tx_valid;
		logic [31:0]                    tx_data;
		logic [1:0]                     tx_queue;
		logic                           tx_first;
		logic                           tx_last;
		logic                           tx_resp_exp;
		logic                           rx_ready;
		logic                           dma_valid;
		logic [31:0]                    dma_data;
		logic [31:0]                    rdata;
		logic                           rvalid;
	} acr_dev_state_t;

	acr_dev_state_t st_r;
	acr_dev_state_t st_nxt;

	// transmit queue choice from the first quadlet
	function automatic logic [1:0] tx_route(input logic [5:0] lbl, input logic [3:0] tc);
		if (acr_pkg::is_resp(tc))
			return acr_pkg::ACR_Q_GENERAL;
		if (tc == acr_pkg::TC_RD_BLK_REQ && lbl[5:2] == 4'h8)
			return acr_pkg::ACR_Q_MGMT;
		if (tc == acr_pkg::TC_RD_BLK_REQ && lbl[5:2] == 4'hc)
			return acr_pkg::ACR_Q_CMD;
		return acr_pkg::ACR_Q_GENERAL;
	endfunction : tx_route

	// receive fifo choice for an incoming response
	function automatic logic [1:0] rx_route(input logic [5:0] lbl, input logic [3:0] tc);
		if (lbl[5:4] == 2'h1)
			return acr_pkg::ACR_Q_DMA;
		if (lbl[5:2] == 4'h8 || lbl == 6'h28)
			return acr_pkg::ACR_Q_MGMT;
		if (lbl[5:2] == 4'hc || (lbl[5:3] == 3'h7 && tc == acr_pkg::TC_RD_BLK_RESP))
			return acr_pkg::ACR_Q_CMD;
		return acr_pkg::ACR_Q_GENERAL;
	endfunction : rx_route

	always_comb begin
		logic [5:0]    lbl;
		logic [3:0]    tc;
		logic [1:0]    sel;
		logic [NF-1:0] push;
		logic [NF-1:0] pop;
		logic          is_wr_port;
		lbl        = bus.wdata[acr_pkg::LABEL_LSB +: 6];
		tc         = bus.wdata[acr_pkg::TCODE_LSB +: 4];
		sel        = st_r.rx_sel;
		push       = '0;
		pop        = '0;
		is_wr_port = 1'b0;
		st_nxt     = st_r;

		// transmit: quadlets forwarded as written, queue fixed by first quadlet
		st_nxt.tx_valid = 1'b0;
		st_nxt.tx_first = 1'b0;
		st_nxt.tx_last  = 1'b0;
		if (bus.wr) begin
			case (bus.adr)
				acr_pkg::ADR_TX_FIRST: begin
					is_wr_port         = 1'b1;
					st_nxt.tx_q        = tx_route(lbl, tc);
					// status block to initiator, sent unified, no response comes
					st_nxt.tx_unsol    = lbl[5:3] == 3'h7 && tc == acr_pkg::TC_WR_BLK_REQ;
					st_nxt.tx_first    = 1'b1;
					st_nxt.tx_resp_exp = !acr_pkg::is_resp(tc) &&
						!st_nxt.tx_unsol;
					st_nxt.tx_queue    = st_nxt.tx_q;
				end
				acr_pkg::ADR_TX_CONT: begin
					is_wr_port      = 1'b1;
					st_nxt.tx_queue = st_r.tx_q;
				end
				acr_pkg::ADR_TX_UPDATE: begin
					is_wr_port      = 1'b1;
					st_nxt.tx_queue = st_r.tx_q;
					st_nxt.tx_last  = 1'b1;
					if (st_r.tx_unsol && st_r.unsol_irq_en)
						st_nxt.unsol_en = 1'b0;
				end
				acr_pkg::ADR_CTRL: begin
					st_nxt.unsol_en     = bus.wdata[acr_pkg::CTRL_UNSOL_EN_BIT];
					st_nxt.unsol_irq_en = bus.wdata[acr_pkg::CTRL_UNSOL_IRQ_BIT];
				end
				default: ;
			endcase
		end
		if (is_wr_port) begin
			st_nxt.tx_valid = 1'b1;
			st_nxt.tx_data  = bus.wdata;
		end

		// receive: first quadlet picks the fifo, rest of packet follows it
		st_nxt.dma_valid = 1'b0;
		if (i_rx_valid && st_r.rx_ready) begin
			if (i_rx_first)
				sel = rx_route(i_rx_data[acr_pkg::LABEL_LSB +: 6],
					i_rx_data[acr_pkg::TCODE_LSB +: 4]);
			st_nxt.rx_sel = sel;
			if (sel == acr_pkg::ACR_Q_DMA) begin
				st_nxt.dma_valid = 1'b1;
				st_nxt.dma_data  = i_rx_data;
			end else begin
				push[sel] = 1'b1;
			end
		end

		// host reads pop the addressed fifo; empty fifo reads as zero
		st_nxt.rvalid = bus.rd;
		st_nxt.rdata  = '0;
		if (bus.rd) begin
			case (bus.adr)
				acr_pkg::ADR_RX_GENERAL,
				acr_pkg::ADR_RX_MGMT,
				acr_pkg::ADR_RX_CMD: begin
					sel = 2'(bus.adr[3:2]);
					if (st_r.cnt[sel] != '0) begin
						pop[sel]     = 1'b1;
						st_nxt.rdata = st_r.mem[sel][st_r.rp[sel]];
					end
				end
				acr_pkg::ADR_CTRL: begin
					st_nxt.rdata[acr_pkg::CTRL_UNSOL_EN_BIT]  = st_r.unsol_en;
					st_nxt.rdata[acr_pkg::CTRL_UNSOL_IRQ_BIT] = st_r.unsol_irq_en;
				end
				default: ;
			endcase
		end

		for (int f = 0; f < NF; f++) begin
			if (push[f]) begin
				st_nxt.mem[f][st_r.wp[f]] = i_rx_data;
				st_nxt.wp[f] = st_r.wp[f] + 1'b1;
			end
			if (pop[f])
				st_nxt.rp[f] = st_r.rp[f] + 1'b1;
			if (push[f] && !pop[f])
				st_nxt.cnt[f] = st_r.cnt[f] + 1'b1;
			else if (pop[f] && !push[f])
				st_nxt.cnt[f] = st_r.cnt[f] - 1'b1;
		end

		// ready leaves one spare slot; taken from the next count, it falls in the same cycle the fill reaches DEPTH-1
		st_nxt.rx_ready = 1'b1;
		for (int f = 0; f < NF; f++) begin
			if (st_nxt.cnt[f] > ROOM)
				st_nxt.rx_ready = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r          <= '0;
			st_r.unsol_en <= acr_pkg::CTRL_RESET[acr_pkg::CTRL_UNSOL_EN_BIT];
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.rdata          = st_r.rdata;
	assign bus.rvalid         = st_r.rvalid;
	assign o_tx_valid         = st_r.tx_valid;
	assign o_tx_data          = st_r.tx_data;
	assign o_tx_queue         = st_r.tx_queue;
	assign o_tx_first         = st_r.tx_first;
	assign o_tx_last          = st_r.tx_last;
	assign o_tx_resp_expected = st_r.tx_resp_exp;
	assign o_rx_ready         = st_r.rx_ready;
	assign o_dma_valid        = st_r.dma_valid;
	assign o_dma_data         = st_r.dma_data;
	assign o_unsol_en         = st_r.unsol_en;
endmodule : acr_device

// ### rtl/acr_host.sv
// Purpose: host end - builds transmit headers, writes them through the ports, reads fifos
// Assumes: payload supplied one quadlet per beat on i_data_*
// Notes:   reserved combinations and undefined speed are refused, nothing is written
`timescale 1ns/1ps
module acr_host (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// register port
	acr_if.host              bus,
	// packet request
	input  wire logic        i_send,
	input  wire logic [1:0]  i_spd,
	input  wire logic [5:0]  i_label,
	input  wire logic [1:0]  i_rt,
	input  wire logic [3:0]  i_tcode,
	input  wire logic [15:0] i_dest_id,
	input  wire logic [47:0] i_dest_offset,
	input  wire logic [15:0] i_data_length,
	input  wire logic [15:0] i_ext_tcode,
	input  wire logic [31:0] i_quad_data,
	output logic             o_busy,
	output logic             o_reject,
	// block payload
	input  wire logic        i_data_valid,
	input  wire logic [31:0] i_data,
	output logic             o_data_ready,
	// register read and control write
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_rd_adr,
	input  wire logic        i_ctrl_wr,
	input  wire logic [1:0]  i_ctrl,
	output logic             o_rd_valid,
	output logic [31:0]      o_rd_data
);
	typedef enum logic [2:0] {ST_IDLE, ST_Q2, ST_Q3, ST_Q4, ST_DATA} acr_hst_phase_t;

	typedef struct packed {
		acr_hst_phase_t phase;
		logic [31:0]    q2;
		logic [31:0]    q3;
		logic [31:0]    q4;
		logic           has_q4;
		logic [13:0]    left;
		logic [7:0]     adr;
		logic           wr;
		logic [31:0]    wdata;
		logic           rd;
		logic           busy;
		logic           reject;
		logic           dready;
		logic           rvalid;
		logic [31:0]    rdata;
	} acr_hst_state_t;

	acr_hst_state_t st_r;
	acr_hst_state_t st_nxt;

	always_comb begin
		logic blk;
		logic [13:0] nq;
		blk    = i_tcode == acr_pkg::TC_WR_BLK_REQ || i_tcode == acr_pkg::TC_RD_BLK_REQ ||
			i_tcode == acr_pkg::TC_RD_BLK_RESP || i_tcode == acr_pkg::TC_LOCK_REQ ||
			i_tcode == acr_pkg::TC_LOCK_RESP;
		nq     = 14'((i_data_length + 16'h3) >> 2);
		st_nxt = st_r;
		st_nxt.wr     = 1'b0;
		st_nxt.rd     = 1'b0;
		st_nxt.reject = 1'b0;
		st_nxt.rvalid = bus.rvalid;
		st_nxt.rdata  = bus.rvalid ? bus.rdata : st_r.rdata;
		case (st_r.phase)
			ST_IDLE: begin
				if (i_send) begin
					if (acr_pkg::is_reserved(i_label, i_tcode) ||
						i_spd == acr_pkg::SPD_UNDEFINED) begin
						st_nxt.reject = 1'b1;
					end else begin
						st_nxt.wr    = 1'b1;
						st_nxt.adr   = acr_pkg::ADR_TX_FIRST;
						st_nxt.wdata = '0;
						st_nxt.wdata[acr_pkg::SPD_LSB +: 2]   = i_spd;
						st_nxt.wdata[acr_pkg::LABEL_LSB +: 6] = i_label;
						st_nxt.wdata[acr_pkg::RT_LSB +: 2]    = i_rt;
						st_nxt.wdata[acr_pkg::TCODE_LSB +: 4] = i_tcode;
						st_nxt.wdata[acr_pkg::PRIOR_LSB +: 4] = 4'h0;
						st_nxt.q2    = {i_dest_id, i_dest_offset[47:32]};
						st_nxt.q3    = i_dest_offset[31:0];
						st_nxt.q4    = blk ? {i_data_length, i_ext_tcode} : i_quad_data;
						// fourth quadlet for block packets, quadlet writes and quadlet read responses
						st_nxt.has_q4 = blk || i_tcode == acr_pkg::TC_WR_QUAD_REQ ||
							i_tcode == acr_pkg::TC_RD_QUAD_RESP;
						st_nxt.left  = (blk && i_tcode != acr_pkg::TC_RD_BLK_REQ) ? nq : '0;
						st_nxt.busy  = 1'b1;
						st_nxt.phase = ST_Q2;
					end
				end else if (i_ctrl_wr) begin
					st_nxt.wr    = 1'b1;
					st_nxt.adr   = acr_pkg::ADR_CTRL;
					st_nxt.wdata = {30'h0, i_ctrl};
				end else if (i_rd) begin
					st_nxt.rd  = 1'b1;
					st_nxt.adr = i_rd_adr;
				end
			end
			ST_Q2: begin
				st_nxt.wr    = 1'b1;
				st_nxt.adr   = acr_pkg::ADR_TX_CONT;
				st_nxt.wdata = st_r.q2;
				st_nxt.phase = ST_Q3;
			end
			ST_Q3: begin
				st_nxt.wr    = 1'b1;
				st_nxt.adr   = st_r.has_q4 ? acr_pkg::ADR_TX_CONT : acr_pkg::ADR_TX_UPDATE;
				st_nxt.wdata = st_r.q3;
				st_nxt.phase = st_r.has_q4 ? ST_Q4 : ST_IDLE;
			end
			ST_Q4: begin
				st_nxt.wr    = 1'b1;
				st_nxt.adr   = st_r.left != '0 ? acr_pkg::ADR_TX_CONT : acr_pkg::ADR_TX_UPDATE;
				st_nxt.wdata = st_r.q4;
				st_nxt.phase = st_r.left != '0 ? ST_DATA : ST_IDLE;
			end
			ST_DATA: begin
				if (i_data_valid && st_r.dready) begin
					st_nxt.wr    = 1'b1;
					st_nxt.adr   = st_r.left == 14'h1 ? acr_pkg::ADR_TX_UPDATE :
						acr_pkg::ADR_TX_CONT;
					st_nxt.wdata = i_data;
					st_nxt.left  = st_r.left - 1'b1;
					if (st_r.left == 14'h1)
						st_nxt.phase = ST_IDLE;
				end
			end
			default: st_nxt.phase = ST_IDLE;
		endcase
		st_nxt.busy   = st_nxt.phase != ST_IDLE;
		st_nxt.dready = st_nxt.phase == ST_DATA;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign bus.adr      = st_r.adr;
	assign bus.wr       = st_r.wr;
	assign bus.wdata    = st_r.wdata;
	assign bus.rd       = st_r.rd;
	assign o_busy       = st_r.busy;
	assign o_reject     = st_r.reject;
	assign o_data_ready = st_r.dready;
	assign o_rd_valid   = st_r.rvalid;
	assign o_rd_data    = st_r.rdata;
endmodule : acr_host

// ### verif/acr_monitor.sv
// Purpose: watches the register port between host and device ends
// Assumes: one clock, asynchronous active-high reset
// Notes:   sees only port signals
`timescale 1ns/1ps
module acr_monitor (
	// clock and reset
	input wire logic	i_clk,
	input wire logic	i_rst,
	// register port
	input wire logic [7:0]	adr,
	input wire logic	wr,
	input wire logic [31:0]	wdata,
	input wire logic	rd,
	input wire logic [31:0]	rdata,
	input wire logic	rvalid
);
	logic		first;
	logic [3:0]	tc;
	logic [5:0]	lbl;
	logic		req;
	assign first = wr && adr == 8'h70;
	assign tc = wdata[7:4];
	assign lbl = wdata[15:10];
	assign req = !(tc inside {4'h2, 4'h6, 4'h7, 4'hb});
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_RD_ANSWER: assert property (rd |=> rvalid)
		else $error("read not answered");
	AST_NO_SPURIOUS: assert property (rvalid |-> $past(rd))
		else $error("answer without read");
	AST_ONE_ACCESS: assert property (!(wr && rd))
		else $error("write and read together");
	AST_WR_MAP: assert property (wr |-> adr inside {8'h50, 8'h70, 8'h74, 8'h78})
		else $error("write to unmapped offset");
	AST_PRIOR_ZERO: assert property (first |-> wdata[3:0] == 4'h0)
		else $error("priority not zero");
	AST_SPD_DEF: assert property (first |-> wdata[17:16] != 2'h3)
		else $error("undefined speed written");
	AST_RSVD_BITS: assert property (first |-> wdata[31:18] == 14'h0)
		else $error("reserved control bits set");
	AST_NO_RSVD_LABEL: assert property (first |-> !(req && lbl[5:4] == 2'h1) &&
		!(tc == 4'h5 && (lbl == 6'h28 || lbl[5:3] == 3'h7)))
		else $error("reserved label written");
	AST_QUAD_NODATA: assert property (first && tc inside {4'h2, 4'h4} |=>
		wr && adr == 8'h74 ##1 wr && adr == 8'h78)
		else $error("bad header without data");
	AST_QUAD_DATA: assert property (first && tc inside {4'h0, 4'h6} |=>
		(wr && adr == 8'h74) [*2] ##1 wr && adr == 8'h78)
		else $error("bad quadlet packet");
	AST_BLK_RD: assert property (first && tc == 4'h5 |=>
		(wr && adr == 8'h74) [*2] ##1 wr && adr == 8'h78)
		else $error("bad block read header");
	AST_BLK_HDR: assert property (first && tc inside {4'h1, 4'h7, 4'h9, 4'hb} |=>
		(wr && adr == 8'h74) [*2] ##1 wr && adr inside {8'h74, 8'h78})
		else $error("bad block header");
	AST_UNMAPPED_ZERO: assert property (rd && !(adr inside {8'h50, 8'h80, 8'h84, 8'h88})
		|=> rdata == 32'h0)
		else $error("unmapped read not zero");
	cover property (first && tc == 4'h5 && lbl[5:2] == 4'h8);
	cover property (rd && adr == 8'h84 ##1 rvalid);
	cover property (first && tc == 4'h1 && lbl[5:3] == 3'h7);
endmodule : acr_monitor

// ### verif/test_async_cmd_fifo_router.sv
// Purpose: drives host and link sides of both ends joined by the port
// Assumes: inputs change at falling edge
// Notes:   small receive depth so back-pressure thresholds stay short
`timescale 1ns/1ps
module test_async_cmd_fifo_router;
	typedef struct packed {
		logic [1:0] spd; logic [5:0] lbl; logic [1:0] rt; logic [3:0] tc;
		logic [15:0] len; logic [1:0] q; logic rsp; logic rej;
	} acr_row_t;
	localparam acr_row_t ROWS [14] = '{
		'{0, 6'h00, 0, 4'h0, 0, 0, 1, 0}, '{1, 6'h0e, 1, 4'h4, 0, 0, 1, 0},
		'{2, 6'h21, 0, 4'h5, 8, 1, 1, 0}, '{1, 6'h33, 2, 4'h5, 32, 2, 1, 0},
		'{0, 6'h3a, 0, 4'h1, 8, 0, 0, 0}, '{2, 6'h15, 3, 4'h2, 0, 0, 0, 0},
		'{0, 6'h30, 0, 4'h6, 0, 0, 0, 0}, '{1, 6'h05, 0, 4'h9, 8, 0, 1, 0},
		'{2, 6'h2c, 0, 4'h7, 5, 0, 0, 0}, '{0, 6'h13, 0, 4'h0, 0, 0, 0, 1},
		'{0, 6'h28, 0, 4'h5, 8, 0, 0, 1}, '{0, 6'h3c, 0, 4'h5, 8, 0, 0, 1},
		'{3, 6'h01, 0, 4'h0, 0, 0, 0, 1}, '{1, 6'h3f, 0, 4'hb, 4, 0, 0, 0}};
	localparam logic [31:0] RXD [7] = '{32'h1460, 32'h1111_0001, 32'h8870, 32'ha070,
		32'hc470, 32'he870, 32'h4c60};
	localparam logic [7:0] RA [9] = '{8'h80, 8'h80, 8'h80, 8'h84, 8'h84, 8'h88, 8'h88, 8'h88,
		8'h7c};
	localparam logic [31:0] RE [9] = '{32'h1460, 32'h1111_0001, 0, 32'h8870, 32'ha070,
		32'hc470, 32'he870, 0, 0};
	logic i_clk, i_rst, i_send, i_data_valid, i_rd, i_ctrl_wr, i_rx_valid, i_rx_first;
	logic [1:0] i_spd, i_rt, i_ctrl, o_tx_queue, tq;
	logic [5:0] i_label;
	logic [3:0] i_tcode;
	logic [15:0] i_dest_id, i_data_length, i_ext_tcode;
	logic [47:0] i_dest_offset;
	logic [31:0] i_quad_data, i_data, o_rd_data, o_tx_data, i_rx_data, o_dma_data, dma_d, d;
	logic [7:0] i_rd_adr;
	logic o_busy, o_reject, o_data_ready, o_rd_valid, o_tx_valid, o_tx_first, o_tx_last;
	logic o_tx_resp_expected, o_rx_ready, o_dma_valid, o_unsol_en, tr, got_last, got_rej;
	logic [31:0] txq [$];
	int miscompares = 0;
	int cmp_count = 0;
	int dr_cnt = 0;
	acr_if acr_if_inst ();
	acr_host acr_host_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(acr_if_inst), .i_send(i_send),
		.i_spd(i_spd), .i_label(i_label), .i_rt(i_rt), .i_tcode(i_tcode),
		.i_dest_id(i_dest_id), .i_dest_offset(i_dest_offset), .i_data_length(i_data_length),
		.i_ext_tcode(i_ext_tcode), .i_quad_data(i_quad_data), .o_busy(o_busy),
		.o_reject(o_reject), .i_data_valid(i_data_valid), .i_data(i_data),
		.o_data_ready(o_data_ready), .i_rd(i_rd), .i_rd_adr(i_rd_adr), .i_ctrl_wr(i_ctrl_wr),
		.i_ctrl(i_ctrl), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
	acr_device #(.DEPTH(4)) acr_device_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(acr_if_inst),
		.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_queue(o_tx_queue),
		.o_tx_first(o_tx_first), .o_tx_last(o_tx_last), .o_tx_resp_expected(o_tx_resp_expected),
		.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_first(i_rx_first),
		.o_rx_ready(o_rx_ready), .o_dma_valid(o_dma_valid), .o_dma_data(o_dma_data),
		.o_unsol_en(o_unsol_en));
	acr_monitor acr_monitor_inst (.i_clk(i_clk), .i_rst(i_rst), .adr(acr_if_inst.adr),
		.wr(acr_if_inst.wr), .wdata(acr_if_inst.wdata), .rd(acr_if_inst.rd),
		.rdata(acr_if_inst.rdata), .rvalid(acr_if_inst.rvalid));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_tx_valid === 1'b1) begin
			txq.push_back(o_tx_data);
			if (o_tx_first === 1'b1) begin
				tq = o_tx_queue;
				tr = o_tx_resp_expected;
			end
			if (o_tx_last === 1'b1) got_last = 1'b1;
		end
		if (o_reject === 1'b1) got_rej = 1'b1;
		if (o_dma_valid === 1'b1) dma_d = o_dma_data;
		if (o_data_ready === 1'b1) dr_cnt++;
	end
	task automatic end_of_test;
		if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic tmo;
		miscompares++;
		end_of_test();
	endtask : tmo
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		int n;
		@(negedge i_clk);
		i_rd = 1'b1;
		i_rd_adr = a;
		@(negedge i_clk);
		i_rd = 1'b0;
		for (n = 0; n < 20 && o_rd_valid !== 1'b1; n++) @(negedge i_clk);
		if (n == 20) tmo();
		v = o_rd_data;
	endtask : rd_reg
	task automatic wctl(input logic [1:0] v);
		@(negedge i_clk);
		i_ctrl_wr = 1'b1;
		i_ctrl = v;
		@(negedge i_clk);
		i_ctrl_wr = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask : wctl
	task automatic send(input acr_row_t r, input logic [31:0] qd);
		int n;
		@(negedge i_clk);
		txq.delete();
		got_last = 1'b0;
		got_rej = 1'b0;
		dr_cnt = 0;
		{i_send, i_spd, i_label, i_rt, i_tcode, i_data_length} = {1'b1, r.spd, r.lbl, r.rt,
			r.tc, r.len};
		{i_quad_data, i_data} = {qd, qd};
		@(negedge i_clk);
		i_send = 1'b0;
		for (n = 0; n < 80 && !(got_last || got_rej); n++) @(negedge i_clk);
		if (n == 80) tmo();
		for (n = 0; n < 20 && o_busy !== 1'b0; n++) @(negedge i_clk);
		if (n == 20) tmo();
	endtask : send
	function automatic int nq(acr_row_t r);
		case (r.tc)
			4'h2, 4'h4: return 3;
			4'h0, 4'h5, 4'h6: return 4;
			default: return 4 + (r.len + 3) / 4;
		endcase
	endfunction : nq
	initial begin
		{i_rst, i_send, i_rd, i_ctrl_wr, i_rx_valid, i_rx_first, i_data_valid} = 7'h41;
		{i_spd, i_label, i_rt, i_tcode, i_data_length, i_quad_data, i_data} = 0;
		{i_rd_adr, i_ctrl, i_rx_data} = 0;
		{i_dest_id, i_dest_offset, i_ext_tcode} = {16'hffc2, 48'hffff_f000_0400, 16'h0002};
		repeat (12) @(negedge i_clk);
		i_rst = 1'b0;
		chk(o_unsol_en, 0);
		rd_reg(8'h50, d);
		chk(d, acr_pkg::CTRL_RESET);
		for (int i = 0; i < 14; i++) begin
			send(ROWS[i], 32'hc0de_0000 | i);
			chk(got_rej, ROWS[i].rej);
			if (ROWS[i].rej) chk(txq.size(), 0);
			else begin
				chk(txq.size(), nq(ROWS[i]));
				chk(dr_cnt, nq(ROWS[i]) > 4 ? nq(ROWS[i]) - 4 : 0);
				chk(tq, ROWS[i].q);
				chk(tr, ROWS[i].rsp);
				chk(txq[0], {14'h0, ROWS[i].spd, ROWS[i].lbl, ROWS[i].rt, ROWS[i].tc, 4'h0});
				chk(txq[1], 32'hffc2_ffff);
				chk(txq[2], 32'hf000_0400);
				if (ROWS[i].tc inside {4'h0, 4'h6}) chk(txq[3], 32'hc0de_0000 | i);
				if (nq(ROWS[i]) > 4) chk(txq[3], {ROWS[i].len, 16'h0002});
				for (int k = 4; k < txq.size(); k++) chk(txq[k], 32'hc0de_0000 | i);
			end
		end
		wctl(2'h3);
		chk(o_unsol_en, 1);
		rd_reg(8'h50, d);
		chk(d, 32'h3);
		send(ROWS[4], 32'h0);
		repeat (2) @(negedge i_clk);
		chk(o_unsol_en, 0);
		wctl(2'h1);
		send(ROWS[4], 32'h0);
		repeat (2) @(negedge i_clk);
		chk(o_unsol_en, 1);
		for (int i = 0; i < 7; i++) begin
			chk(o_rx_ready, 1);
			{i_rx_valid, i_rx_first, i_rx_data} = {1'b1, i != 1, RXD[i]};
			@(negedge i_clk);
		end
		i_rx_valid = 1'b0;
		repeat (2) @(negedge i_clk);
		chk(dma_d, 32'h4c60);
		for (int i = 0; i < 9; i++) begin
			rd_reg(RA[i], d);
			chk(d, RE[i]);
		end
		// back-pressure: ready falls once a fifo holds DEPTH-1, later quadlets are not taken
		{i_rx_valid, i_rx_first, i_rx_data} = {1'b1, 1'b1, 32'h1460};
		for (int i = 2; i < 6; i++) begin
			@(negedge i_clk);
			{i_rx_first, i_rx_data} = {1'b0, 32'(i)};
		end
		i_rx_valid = 1'b0;
		chk(o_rx_ready, 0);
		for (int i = 0; i < 4; i++) begin
			rd_reg(8'h80, d);
			chk(d, i == 0 ? 32'h1460 : i == 3 ? 32'h0 : 32'(i + 1));
		end
		chk(o_rx_ready, 1);
		i_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		chk(o_unsol_en, 0);
		end_of_test();
	end
endmodule : test_async_cmd_fifo_router
